// *** qdsd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// RQ1: sync falling edge starts frame, clears partial.
// RQ2: write-only three-line serial port, nothing returned.
// RQ3: load 00 stores data in selected input.
// RQ4: load 01 copies selected input to DAC.
// RQ5: load 10 writes selected input and DAC.
// RQ6: load 11 broadcasts input, transfer or both.
// RQ7: all control bits one means power-down.
// RQ8: DAC register write updates output; input alone not.
// RQ9: power-down bit11 all, 10..9 channel, 8..7 mode.
// RQ10: DAC code is unsigned twelve-bit binary.
// RQ11: sixteen bits MSB first, sampled on falling edge.
// RQ12: act only after sixteenth bit; aborts ignored.
module qdsd_decoder (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_sync_n,
	input wire logic i_sdin,
	input wire logic [qdsd_pkg::ADDR_W-1:0] i_s_axi_awaddr,
	input wire logic i_s_axi_awvalid,
	output logic o_s_axi_awready,
	input wire logic [qdsd_pkg::DATA_W-1:0] i_s_axi_wdata,
	input wire logic [3:0] i_s_axi_wstrb,
	input wire logic i_s_axi_wvalid,
	output logic o_s_axi_wready,
	output logic [1:0] o_s_axi_bresp,
	output logic o_s_axi_bvalid,
	input wire logic i_s_axi_bready,
	input wire logic [qdsd_pkg::ADDR_W-1:0] i_s_axi_araddr,
	input wire logic i_s_axi_arvalid,
	output logic o_s_axi_arready,
	output logic [qdsd_pkg::DATA_W-1:0] o_s_axi_rdata,
	output logic [1:0] o_s_axi_rresp,
	output logic o_s_axi_rvalid,
	input wire logic i_s_axi_rready,
	output logic [qdsd_pkg::CODE_W-1:0] o_analog_out_a,
	output logic [qdsd_pkg::CODE_W-1:0] o_analog_out_b,
	output logic [qdsd_pkg::CODE_W-1:0] o_analog_out_c,
	output logic [qdsd_pkg::CODE_W-1:0] o_analog_out_d,
	output logic [qdsd_pkg::CHANNELS-1:0] o_output_shutdown,
	output logic [2*qdsd_pkg::CHANNELS-1:0] o_shutdown_mode
);
	localparam int NCH = qdsd_pkg::CHANNELS;
	localparam int CW = qdsd_pkg::CODE_W;

	qdsd_pkg::qdsd_frame_s link_word;
	logic link_toggle, tog_meta, tog_sync, tog_seen, frame_new;
	qdsd_pkg::qdsd_frame_s frame_q;
	logic frame_go, ctrl_en;
	logic [15:0] frame_count;
	logic [CW-1:0] input_reg [NCH];
	logic [CW-1:0] dac_reg [NCH];
	logic [NCH-1:0] shut_on;
	logic [1:0] shut_mode [NCH];
	logic [1:0] load_sel, pick;
	qdsd_pkg::qdsd_chan_wr_s chan_wr [NCH];

	qdsd_link_rx u_link (
		.i_rst_n(i_rst_n),
		.i_sclk(i_sclk),
		.i_sync_n(i_sync_n),
		.i_sdin(i_sdin),
		.o_word(link_word),
		.o_done_toggle(link_toggle)
	);

	// toggle crossing; the word is held on the link side for at least
	// sixteen serial clocks, far longer than the three-cycle sync delay
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_seen <= 1'b0;
		end else begin
			tog_meta <= link_toggle;
			tog_sync <= tog_meta;
			tog_seen <= tog_sync;
		end
	end
	assign frame_new = tog_sync ^ tog_seen;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_q <= '0;
			frame_go <= 1'b0;
		end else begin
			frame_go <= frame_new & ctrl_en; // see RQ12
			if (frame_new) begin
				frame_q <= link_word;
			end
		end
	end
	assign load_sel = {frame_q.load_ctrl_hi, frame_q.load_ctrl_lo};
	assign pick = {frame_q.chan_pick_hi, frame_q.chan_pick_lo};
	function automatic qdsd_pkg::qdsd_chan_wr_s chan_action(
		input logic [1:0] ld,
		input logic [1:0] sel,
		input logic [11:0] code,
		input int ch
	);
		qdsd_pkg::qdsd_chan_wr_s act;
		logic mine;
		act = '0;
		mine = (sel == ch[1:0]);
		case (ld)
			qdsd_pkg::LOAD_INPUT: act.wr_input = mine; // see RQ3
			qdsd_pkg::LOAD_XFER: act.wr_dac_xfer = mine; // see RQ4
			qdsd_pkg::LOAD_BOTH: begin // see RQ5
				act.wr_input = mine;
				act.wr_dac_code = mine;
			end
			qdsd_pkg::LOAD_WIDE: begin // see RQ6
				case (sel)
					qdsd_pkg::WIDE_INPUT: act.wr_input = 1'b1;
					qdsd_pkg::WIDE_XFER: act.wr_dac_xfer = 1'b1;
					qdsd_pkg::WIDE_BOTH: begin
						act.wr_input = 1'b1;
						act.wr_dac_code = 1'b1;
					end
					default: begin // see RQ7
						act.shut = code[qdsd_pkg::PD_ALL_POS] ||
							code[qdsd_pkg::PD_CHAN_HI:qdsd_pkg::PD_CHAN_LO]
							== ch[1:0]; // see RQ9
					end
				endcase
			end
			default: act = '0;
		endcase
		return act;
	endfunction : chan_action
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_chan
			assign chan_wr[c] = chan_action(load_sel, pick,
				frame_q.code_bits, c);
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					input_reg[c] <= '0;
				end else if (frame_go && chan_wr[c].wr_input) begin
					input_reg[c] <= frame_q.code_bits;
				end
			end
			// old input value is read on a transfer in the same cycle
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					dac_reg[c] <= '0;
				end else if (frame_go && chan_wr[c].wr_dac_code) begin
					dac_reg[c] <= frame_q.code_bits; // see RQ8
				end else if (frame_go && chan_wr[c].wr_dac_xfer) begin
					dac_reg[c] <= input_reg[c]; // see RQ8
				end
			end
			// a new DAC code wakes the channel from shutdown
			always_ff @(posedge i_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					shut_on[c] <= 1'b0;
					shut_mode[c] <= qdsd_pkg::MODE_HIZ;
				end else if (frame_go && chan_wr[c].shut) begin
					shut_on[c] <= 1'b1; // see RQ9
					shut_mode[c] <= frame_q.code_bits[
						qdsd_pkg::PD_MODE_HI:qdsd_pkg::PD_MODE_LO];
				end else if (frame_go && (chan_wr[c].wr_dac_code ||
					chan_wr[c].wr_dac_xfer)) begin
					shut_on[c] <= 1'b0;
				end
			end
			assign o_shutdown_mode[2*c+1:2*c] = shut_mode[c];
		end
	endgenerate
	// codes leave as plain unsigned binary, full range 0 to 4095
	assign o_analog_out_a = dac_reg[0]; // see RQ10
	assign o_analog_out_b = dac_reg[1];
	assign o_analog_out_c = dac_reg[2];
	assign o_analog_out_d = dac_reg[3];
	assign o_output_shutdown = shut_on;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			frame_count <= 16'h0000;
		end else if (frame_go) begin
			frame_count <= frame_count + 16'h0001;
		end
	end

	function automatic qdsd_pkg::qdsd_reg_e reg_kind(
		input logic [qdsd_pkg::ADDR_W-1:0] a
	);
		if (a[1:0] != 2'h0) begin
			return qdsd_pkg::REG_NONE;
		end else if (a == qdsd_pkg::OFS_CTRL) begin
			return qdsd_pkg::REG_CTRL;
		end else if (a == qdsd_pkg::OFS_STATUS) begin
			return qdsd_pkg::REG_STATUS;
		end else if (a == qdsd_pkg::OFS_SHUT) begin
			return qdsd_pkg::REG_SHUT;
		end else if (a[7:4] == qdsd_pkg::OFS_INPUT_BASE[7:4]) begin
			return qdsd_pkg::REG_INPUT;
		end else if (a[7:4] == qdsd_pkg::OFS_DAC_BASE[7:4]) begin
			return qdsd_pkg::REG_DAC;
		end
		return qdsd_pkg::REG_NONE;
	endfunction : reg_kind

	logic [qdsd_pkg::ADDR_W-1:0] aw_addr;
	logic [qdsd_pkg::DATA_W-1:0] w_data;
	logic [3:0] w_strb;
	logic aw_held, w_held, do_write;
	logic next_aw_held, next_w_held, next_b_valid, next_r_valid;
	logic [qdsd_pkg::DATA_W-1:0] rd_value;
	logic [1:0] rd_resp;

	assign do_write = aw_held & w_held & ~o_s_axi_bvalid;
	assign next_b_valid = o_s_axi_bvalid ? ~i_s_axi_bready :
		(aw_held & w_held);
	assign next_aw_held = aw_held ? ~do_write :
		(i_s_axi_awvalid & o_s_axi_awready);
	assign next_w_held = w_held ? ~do_write :
		(i_s_axi_wvalid & o_s_axi_wready);
	assign next_r_valid = o_s_axi_rvalid ? ~i_s_axi_rready :
		(i_s_axi_arvalid & o_s_axi_arready);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			o_s_axi_awready <= 1'b0;
			o_s_axi_wready <= 1'b0;
			o_s_axi_bvalid <= 1'b0;
			aw_addr <= '0;
			w_data <= '0;
			w_strb <= 4'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			o_s_axi_awready <= ~next_aw_held & ~next_b_valid;
			o_s_axi_wready <= ~next_w_held & ~next_b_valid;
			o_s_axi_bvalid <= next_b_valid;
			if (i_s_axi_awvalid && o_s_axi_awready) begin
				aw_addr <= i_s_axi_awaddr;
			end
			if (i_s_axi_wvalid && o_s_axi_wready) begin
				w_data <= i_s_axi_wdata;
				w_strb <= i_s_axi_wstrb;
			end
		end
	end
	// only the enable is writable; the rest is status
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_en <= qdsd_pkg::CTRL_EN_RST;
			o_s_axi_bresp <= qdsd_pkg::RESP_OKAY;
		end else if (do_write) begin
			o_s_axi_bresp <= (reg_kind(aw_addr) == qdsd_pkg::REG_NONE) ?
				qdsd_pkg::RESP_DECERR : qdsd_pkg::RESP_OKAY;
			if (reg_kind(aw_addr) == qdsd_pkg::REG_CTRL && w_strb[0]) begin
				ctrl_en <= w_data[qdsd_pkg::CTRL_EN_POS];
			end
		end
	end
	always_comb begin
		rd_value = '0;
		rd_resp = qdsd_pkg::RESP_OKAY;
		case (reg_kind(i_s_axi_araddr))
			qdsd_pkg::REG_CTRL: rd_value[qdsd_pkg::CTRL_EN_POS] = ctrl_en;
			qdsd_pkg::REG_STATUS: begin
				rd_value[15:0] = frame_count;
				rd_value[qdsd_pkg::STATUS_EN_POS] = ctrl_en;
			end
			qdsd_pkg::REG_SHUT: begin
				rd_value[NCH-1:0] = shut_on;
				rd_value[qdsd_pkg::SHUT_MODE_POS +: 2*NCH] = o_shutdown_mode;
			end
			qdsd_pkg::REG_INPUT:
				rd_value[CW-1:0] = input_reg[i_s_axi_araddr[3:2]];
			qdsd_pkg::REG_DAC:
				rd_value[CW-1:0] = dac_reg[i_s_axi_araddr[3:2]];
			default: rd_resp = qdsd_pkg::RESP_DECERR;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_s_axi_arready <= 1'b0;
			o_s_axi_rvalid <= 1'b0;
			o_s_axi_rdata <= '0;
			o_s_axi_rresp <= qdsd_pkg::RESP_OKAY;
		end else begin
			o_s_axi_arready <= ~next_r_valid;
			o_s_axi_rvalid <= next_r_valid;
			if (i_s_axi_arvalid && o_s_axi_arready) begin
				o_s_axi_rdata <= rd_value;
				o_s_axi_rresp <= rd_resp;
			end
		end
	end
	a_input_store: assert property ( // see RQ3
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_INPUT |=>
		input_reg[$past(pick)] == $past(frame_q.code_bits) &&
		$stable(o_analog_out_a) && $stable(o_analog_out_d))
	else $error("single store wrong or DAC disturbed");
	a_single_xfer: assert property ( // see RQ4
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_XFER |=>
		dac_reg[$past(pick)] == $past(input_reg[pick]))
	else $error("single transfer did not copy input");
	a_single_both: assert property ( // see RQ5
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_BOTH |=>
		dac_reg[$past(pick)] == $past(frame_q.code_bits) &&
		input_reg[$past(pick)] == $past(frame_q.code_bits))
	else $error("single update missed a register");
	a_wide_input: assert property ( // see RQ6
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_INPUT |=>
		input_reg[0] == $past(frame_q.code_bits) &&
		input_reg[3] == $past(frame_q.code_bits))
	else $error("broadcast store missed a channel");
	a_wide_xfer: assert property ( // see RQ6
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_XFER |=>
		o_analog_out_b == $past(input_reg[1]) &&
		o_analog_out_c == $past(input_reg[2]))
	else $error("broadcast transfer missed a channel");
	a_shut_all: assert property ( // see RQ9
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_SHUTDOWN &&
		frame_q.code_bits[qdsd_pkg::PD_ALL_POS] |=>
		o_output_shutdown == 4'hf &&
		o_shutdown_mode[1:0] == $past(frame_q.code_bits[8:7]))
	else $error("all-channel shutdown not applied");
	a_shut_keeps_code: assert property ( // see RQ7
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_SHUTDOWN |=>
		$stable(o_analog_out_a) && $stable(o_analog_out_b))
	else $error("power-down frame changed a code");
	a_out_cause: assert property ( // see RQ8
		@(posedge i_clk) disable iff (!i_rst_n)
		$changed(o_analog_out_a) |-> $past(frame_go) &&
		$past(load_sel) != qdsd_pkg::LOAD_INPUT)
	else $error("output moved without a DAC write");
	a_frame_latency: assert property ( // see RQ12
		@(posedge i_clk) disable iff (!i_rst_n)
		frame_new && ctrl_en |=> frame_go ##1 !frame_go)
	else $error("completed frame not acted on once");
	a_idle_hold: assert property ( // see RQ12
		@(posedge i_clk) disable iff (!i_rst_n)
		!frame_go |=> $stable(input_reg[2]) && $stable(dac_reg[2]) &&
		$stable(shut_on))
	else $error("registers changed without a frame");
	c_wide_both: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_BOTH);
	c_shut_one: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		frame_go && load_sel == qdsd_pkg::LOAD_WIDE &&
		pick == qdsd_pkg::WIDE_SHUTDOWN &&
		!frame_q.code_bits[qdsd_pkg::PD_ALL_POS]);
	c_wake: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		shut_on[0] ##[1:200] !shut_on[0]);
	c_bus_read: cover property (@(posedge i_clk) disable iff (!i_rst_n)
		o_s_axi_rvalid && i_s_axi_rready);
endmodule : qdsd_decoder
`default_nettype wire

// *** qdsd_pkg.sv ***
package qdsd_pkg;
	localparam int CHANNELS = 4;
	localparam int CODE_W = 12;
	localparam int FRAME_BITS = 16;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// link bit counter values
	localparam logic [4:0] FRAME_LAST_BIT = 5'h0f;
	localparam logic [4:0] FRAME_FULL = 5'h10;

	// power-down fields inside the twelve code bits
	localparam int PD_ALL_POS = 11;
	localparam int PD_CHAN_HI = 10;
	localparam int PD_CHAN_LO = 9;
	localparam int PD_MODE_HI = 8;
	localparam int PD_MODE_LO = 7;

	// load-control values
	localparam logic [1:0] LOAD_INPUT = 2'h0;
	localparam logic [1:0] LOAD_XFER = 2'h1;
	localparam logic [1:0] LOAD_BOTH = 2'h2;
	localparam logic [1:0] LOAD_WIDE = 2'h3;

	// channel-pick values under wide load
	localparam logic [1:0] WIDE_INPUT = 2'h0;
	localparam logic [1:0] WIDE_XFER = 2'h1;
	localparam logic [1:0] WIDE_BOTH = 2'h2;
	localparam logic [1:0] WIDE_SHUTDOWN = 2'h3;

	// output states while shut down
	localparam logic [1:0] MODE_HIZ = 2'h0;
	localparam logic [1:0] MODE_1K = 2'h1;
	localparam logic [1:0] MODE_100K = 2'h2;
	localparam logic [1:0] MODE_HIZ_ALT = 2'h3;

	// register map, byte addresses
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_SHUT = 8'h08;
	localparam logic [7:0] OFS_INPUT_BASE = 8'h10;
	localparam logic [7:0] OFS_DAC_BASE = 8'h20;
	localparam int CTRL_EN_POS = 0;
	localparam int SHUT_MODE_POS = 4;
	localparam int STATUS_EN_POS = 16;
	localparam logic CTRL_EN_RST = 1'h1;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum {
		REG_CTRL,
		REG_STATUS,
		REG_SHUT,
		REG_INPUT,
		REG_DAC,
		REG_NONE
	} qdsd_reg_e;

	typedef struct packed {
		logic load_ctrl_hi;
		logic load_ctrl_lo;
		logic chan_pick_hi;
		logic chan_pick_lo;
		logic [11:0] code_bits;
	} qdsd_frame_s;

	typedef struct packed {
		logic wr_input;
		logic wr_dac_code;
		logic wr_dac_xfer;
		logic shut;
	} qdsd_chan_wr_s;
endpackage : qdsd_pkg

// *** qdsd_link_rx.sv ***
`timescale 1ns/1ps
`default_nettype none
module qdsd_link_rx (
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_sync_n,
	input wire logic i_sdin,
	output qdsd_pkg::qdsd_frame_s o_word,
	output logic o_done_toggle
);
	logic frame_rst_n;
	logic [4:0] bit_count;
	logic [14:0] shift;

	// frame sync high holds the shifter cleared, so a new low starts clean
	assign frame_rst_n = i_rst_n & ~i_sync_n; // see RQ1

	// only listens; nothing is ever driven back to the host
	always_ff @(negedge i_sclk or negedge frame_rst_n) begin // see RQ2
		if (!frame_rst_n) begin
			bit_count <= 5'h00;
			shift <= 15'h0000;
		end else if (bit_count != qdsd_pkg::FRAME_FULL) begin // see RQ11
			shift <= {shift[13:0], i_sdin};
			bit_count <= bit_count + 5'h01;
		end
	end

	// word and toggle survive frame sync so a finished frame is not lost
	always_ff @(negedge i_sclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_word <= '0;
			o_done_toggle <= 1'b0;
		end else if (!i_sync_n && bit_count == qdsd_pkg::FRAME_LAST_BIT) begin
			o_word <= {shift, i_sdin}; // see RQ12
			o_done_toggle <= ~o_done_toggle;
		end
	end

	a_count_bound: assert property ( // see RQ11
		@(negedge i_sclk) disable iff (!frame_rst_n)
		bit_count <= qdsd_pkg::FRAME_FULL)
	else $error("bit counter ran past a full frame");

	a_done_on_last: assert property ( // see RQ12
		@(negedge i_sclk) disable iff (!i_rst_n)
		$changed(o_done_toggle) |-> $past(bit_count) == qdsd_pkg::FRAME_LAST_BIT)
	else $error("frame completed before sixteen bits");

	a_sync_clears: assert property ( // see RQ1
		@(negedge i_sclk) disable iff (!i_rst_n)
		i_sync_n |-> bit_count == 5'h00)
	else $error("shift state kept while frame sync high");
endmodule : qdsd_link_rx
`default_nettype wire

// *** qdsd_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// serial host: the link clock only runs inside a frame, 12 ns period
module qdsd_host_model (
	output logic o_sclk,
	output logic o_sync_n,
	output logic o_sdin
);
	initial begin
		o_sclk = 1'b1;
		o_sync_n = 1'b1;
		o_sdin = 1'b0;
	end

	// nb below sixteen aborts the frame by raising sync early
	task automatic send(input logic [15:0] w, input int nb);
		o_sync_n = 1'b0;
		#3;
		for (int i = 0; i < nb; i++) begin
			o_sdin = w[15-i];
			#6 o_sclk = 1'b0;
			#6 o_sclk = 1'b1;
		end
		#3 o_sync_n = 1'b1;
		// released line must not keep showing the last bit
		o_sdin = ~o_sdin;
		#24;
	endtask : send
endmodule : qdsd_host_model
`default_nettype wire

// *** tb_qdsd_decoder.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_qdsd_decoder;
	logic i_clk, i_rst_n;
	wire logic sclk, sync_n, sdin;
	logic [7:0] awaddr, araddr, mode, e_mode;
	logic awvalid, wvalid, bready, arvalid, rready, e_en;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb, shut, e_shut;
	logic [1:0] bresp, rresp, r;
	logic [11:0] outs [4];
	logic [11:0] e_in [4];
	logic [11:0] e_dac [4];
	int errors, comparisons, e_cnt;

	qdsd_host_model i_qdsd_host_model (.o_sclk(sclk), .o_sync_n(sync_n),
		.o_sdin(sdin));
	qdsd_decoder i_qdsd_decoder (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_sclk(sclk), .i_sync_n(sync_n), .i_sdin(sdin),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awvalid),
		.o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
		.i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid),
		.o_s_axi_wready(wready), .o_s_axi_bresp(bresp),
		.o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
		.i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid),
		.o_s_axi_arready(arready), .o_s_axi_rdata(rdata),
		.o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
		.i_s_axi_rready(rready), .o_analog_out_a(outs[0]),
		.o_analog_out_b(outs[1]), .o_analog_out_c(outs[2]),
		.o_analog_out_d(outs[3]), .o_output_shutdown(shut),
		.o_shutdown_mode(mode));

	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic chk_resp(input string what, input logic [1:0] exp,
		input logic [1:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_resp

	// waits for the answer however long it takes; the watchdog ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge i_clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				r = bresp;
				bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic done;
		done = 1'b0;
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge i_clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid && rready) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : rd

	// outputs settle on the fourth clock edge after the last serial bit
	task automatic frame(input logic [15:0] w, input int nb);
		i_qdsd_host_model.send(w, nb);
		if (nb == 16 && e_en) e_cnt++;
		repeat (6) @(posedge i_clk);
	endtask : frame

	task automatic set_dac(input int c, input logic [11:0] v);
		e_dac[c] = v;
		e_shut[c] = 1'b0;
	endtask : set_dac

	task automatic check_all;
		for (int c = 0; c < 4; c++) begin
			chk("dac out", 32'(e_dac[c]), 32'(outs[c]));
			rd(qdsd_pkg::OFS_INPUT_BASE + 8'(4 * c));
			chk("input reg", 32'(e_in[c]), d);
			rd(qdsd_pkg::OFS_DAC_BASE + 8'(4 * c));
			chk("dac reg", 32'(e_dac[c]), d);
			chk_resp("dac rresp", qdsd_pkg::RESP_OKAY, r);
		end
		chk("shutdown", 32'(e_shut), 32'(shut));
		chk("mode", 32'(e_mode), 32'(mode));
		rd(qdsd_pkg::OFS_SHUT);
		chk("shut reg", {20'h0, e_mode, e_shut}, d);
		rd(qdsd_pkg::OFS_STATUS);
		chk("status", {15'h0, e_en, 16'(e_cnt)}, d);
	endtask : check_all

	task automatic t_reset;
		check_all();
		rd(8'h00);
		chk("ctrl", 32'h1, d);
		rd(8'hfc);
		chk_resp("unmapped rd", 2'h3, r);
		chk("unmapped data", 32'h0, d);
		wr(8'h04, 32'hffffffff);
		chk_resp("ro write", 2'h0, r);
		wr(8'hfc, 32'h0);
		chk_resp("unmapped wr", qdsd_pkg::RESP_DECERR, r);
		rd(qdsd_pkg::OFS_CTRL);
		chk("ctrl after writes", 32'h1, d);
	endtask : t_reset

	task automatic t_store;
		logic [11:0] v;
		for (int c = 0; c < 4; c++) begin
			v = 12'h8a1 + 12'(12'h111 * c);
			frame({2'b00, 2'(c), v}, 16);
			e_in[c] = v;
			check_all();
		end
	endtask : t_store

	task automatic t_single;
		frame({2'b01, 2'b01, 12'hfff}, 16);
		set_dac(1, e_in[1]);
		check_all();
		frame({2'b10, 2'b10, 12'h5a3}, 16);
		e_in[2] = 12'h5a3;
		set_dac(2, 12'h5a3);
		check_all();
	endtask : t_single

	task automatic t_wide;
		frame({4'hc, 12'h0ff}, 16);
		for (int c = 0; c < 4; c++) e_in[c] = 12'h0ff;
		check_all();
		frame({4'hd, 12'h000}, 16);
		for (int c = 0; c < 4; c++) set_dac(c, e_in[c]);
		check_all();
		frame({4'he, 12'hf00}, 16);
		for (int c = 0; c < 4; c++) e_in[c] = 12'hf00;
		for (int c = 0; c < 4; c++) set_dac(c, 12'hf00);
		check_all();
	endtask : t_wide

	// single channels first, so each frame is seen to leave the others alone
	task automatic t_shut;
		for (int c = 0; c < 4; c++) begin
			frame({4'hf, 1'b0, 2'(c), 2'(3 - c), 7'h00}, 16);
			e_shut[c] = 1'b1;
			e_mode[2*c +: 2] = 2'(3 - c);
			check_all();
		end
		frame({4'hf, 1'b1, 2'b10, 2'b01, 7'h7f}, 16);
		e_shut = 4'hf;
		e_mode = 8'h55;
		check_all();
		frame({4'hd, 12'h000}, 16);
		for (int c = 0; c < 4; c++) set_dac(c, e_in[c]);
		check_all();
	endtask : t_shut

	task automatic t_abort;
		frame({2'b10, 2'b00, 12'h3c3}, 10);
		check_all();
		frame({2'b00, 2'b00, 12'h3c3}, 16);
		e_in[0] = 12'h3c3;
		check_all();
	endtask : t_abort

	task automatic t_enable;
		wr(8'h00, 32'h0);
		e_en = 1'b0;
		frame({2'b10, 2'b11, 12'h111}, 16);
		check_all();
		wr(8'h00, 32'h1);
		e_en = 1'b1;
		frame({2'b10, 2'b11, 12'h111}, 16);
		e_in[3] = 12'h111;
		set_dac(3, 12'h111);
		check_all();
	endtask : t_enable

	task automatic wrap_up;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	initial begin
		#400us;
		errors++;
		wrap_up();
	end

	initial begin
		i_rst_n = 1'b0;
		{awaddr, araddr, wdata} = '0;
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		wstrb = 4'hf;
		for (int c = 0; c < 4; c++) e_in[c] = '0;
		for (int c = 0; c < 4; c++) e_dac[c] = '0;
		e_shut = '0;
		e_mode = '0;
		e_en = 1'b1;
		e_cnt = 0;
		repeat (3) @(posedge i_clk);
		i_rst_n <= 1'b1;
		repeat (2) @(posedge i_clk);
		t_reset();
		t_store();
		t_single();
		t_wide();
		t_shut();
		t_abort();
		t_enable();
		wrap_up();
	end
endmodule : tb_qdsd_decoder
`default_nettype wire
